// *** rtl/ocdc_pkg.sv ***
package ocdc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register map, byte wide registers on the serial port
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_IMAGE_REV = 8'h09;
    localparam logic [7:0] OFS_DEVICE_CONTROL = 8'h0a;
    localparam logic [7:0] OFS_MARGIN_HI = 8'h10;

    // device_control fields
    localparam int BIT_PD = 6;
    localparam int BIT_CAL = 1;
    localparam int BIT_AUTO = 0;
    localparam logic [7:0] DEVICE_CONTROL_HOST_MASK = 8'h7d;
    localparam logic [7:0] DEVICE_CONTROL_RD_MASK = 8'h7f;
    localparam logic [7:0] MARGIN_RD_MASK = 8'h03;
    localparam int MARGIN_HI_W = 2;

    // reset values
    localparam logic [7:0] RST_IMAGE_REV = 8'h00;
    localparam logic [7:0] RST_DEVICE_CONTROL = 8'h01;
    localparam logic [7:0] RST_MARGIN_HI = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // nonvolatile image layout
    localparam int NVM_AW = 2;
    localparam int NVM_WORDS = 3;
    localparam logic [1:0] NVM_IDX_REV = 2'h0;
    localparam logic [1:0] NVM_IDX_CTL = 2'h1;
    localparam logic [1:0] NVM_IDX_MARGIN = 2'h2;
    localparam logic [1:0] NVM_IDX_END = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int CAL_TIME_NS_DEF = 2000;
    localparam int CAL_CNT_W = 16;
    localparam int PS_PER_NS = 1000;

    // startup and operating states
    typedef enum logic [2:0] {
        ST_LOAD,
        ST_CONFIG,
        ST_HALT,
        ST_PLL_OFF,
        ST_CAL,
        ST_LOCK,
        ST_RUN
    } ocdc_state_e;

    // one register access from the serial port engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ocdc_req_s;

    // controls toward the synthesizer
    typedef struct packed {
        logic pllEnable;
        logic calReset;
        logic calBusy;
        logic outEnable;
    } ocdc_pll_s;

endpackage

// *** rtl/ocdc_nvm_image.sv ***
`timescale 1ns/1ps
module ocdc_nvm_image #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4,
    parameter int AW = 2,
    parameter logic [DEPTH*WIDTH-1:0] INIT = '0
) (
    // clock and power-on reset
    input wire logic mclk,
    input wire logic rst,
    // write port from the commit engine
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // registered read port
    input wire logic rdEn,
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);

    if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_chk
        $error("ocdc_nvm_image: DEPTH does not fit AW");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] rdData_reg;
    logic [WIDTH-1:0] rdData_next;

    ////////////////////////////////////////////////////////////////////////////////
    // one word per entry; power-on reset stands in for the factory image
    for (genvar i = 0; i < DEPTH; i++) begin : g_word
        logic [WIDTH-1:0] word_next;
        always_comb begin
            word_next = mem_reg[i];
            if (wrEn && wrAddr == AW'(i)) begin
                word_next = wrData;
            end
        end
        always_ff @(posedge mclk) begin
            if (rst) begin
                mem_reg[i] <= INIT[i*WIDTH +: WIDTH];
            end else begin
                mem_reg[i] <= word_next;
            end
        end
    end

    // read data leaves from a register; out of range reads give zero
    always_comb begin
        rdData_next = rdData_reg;
        if (rdEn) begin
            rdData_next = (int'(rdAddr) < DEPTH) ? mem_reg[rdAddr] : '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdData_reg <= '0;
        end else begin
            rdData_reg <= rdData_next;
        end
    end

    assign rdData = rdData_reg;

endmodule

// *** rtl/ocdc_device_ctl.sv ***
`timescale 1ns/1ps
module ocdc_device_ctl #(
    parameter int CAL_TIME_NS = ocdc_pkg::CAL_TIME_NS_DEF,
    // arbitrary image contents standing in for the factory image
    parameter logic [7:0] IMAGE_REV_INIT = 8'h00,
    parameter logic [7:0] DEVICE_CONTROL_INIT = ocdc_pkg::RST_DEVICE_CONTROL,
    parameter logic [7:0] MARGIN_HI_INIT = ocdc_pkg::RST_MARGIN_HI
) (
    // clock and power-on reset
    input wire logic mclk,
    input wire logic rst,
    // other reset sources
    input wire logic hwResetPinN,
    input wire logic swResetReq,
    // register access from the serial port engine
    input wire ocdc_pkg::ocdc_req_s regReq,
    output logic [ocdc_pkg::DATA_W-1:0] regRdata,
    output logic regRdValid,
    // nonvolatile image
    input wire logic nvmWrEn,
    input wire logic [ocdc_pkg::NVM_AW-1:0] nvmWrAddr,
    input wire logic [ocdc_pkg::DATA_W-1:0] nvmWrData,
    input wire logic nvmCommit,
    // synthesizer
    input wire logic pllLockRaw,
    output ocdc_pkg::ocdc_pll_s pllCtl,
    output logic [ocdc_pkg::MARGIN_HI_W-1:0] marginHigh
);

    localparam int CAL_CYCLES_RAW =
        (CAL_TIME_NS * ocdc_pkg::PS_PER_NS + ocdc_pkg::CLK_PERIOD_PS - 1)
        / ocdc_pkg::CLK_PERIOD_PS;
    localparam int CAL_CYCLES = (CAL_CYCLES_RAW < 1) ? 1 : CAL_CYCLES_RAW;
    localparam logic [ocdc_pkg::CAL_CNT_W-1:0] CAL_LAST =
        ocdc_pkg::CAL_CNT_W'(CAL_CYCLES - 1);

    if (CAL_TIME_NS < 1 || CAL_CYCLES >= (1 << ocdc_pkg::CAL_CNT_W)) begin : g_chk
        $error("ocdc_device_ctl: CAL_TIME_NS out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reset pin synchroniser, three stages, change taken when stages two and three agree
    logic [2:0] pinSync_reg;
    logic [2:0] pinSync_next;
    logic pinLevel_reg;
    logic pinLevel_next;

    always_comb begin
        pinSync_next = {pinSync_reg[1:0], hwResetPinN};
        pinLevel_next = pinLevel_reg;
        if (pinSync_reg[1] == pinSync_reg[2]) begin
            pinLevel_next = pinSync_reg[2];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pinSync_reg <= 3'h7;
            pinLevel_reg <= 1'b1;
        end else begin
            pinSync_reg <= pinSync_next;
            pinLevel_reg <= pinLevel_next;
        end
    end

    // any of the three sources restarts the device
    logic devRst;
    assign devRst = rst || !pinLevel_reg || swResetReq;

    ////////////////////////////////////////////////////////////////////////////////
    // nonvolatile image, read one word at a time
    logic memRdEn;
    logic [ocdc_pkg::NVM_AW-1:0] memRdAddr;
    logic [ocdc_pkg::DATA_W-1:0] memRdData;

    ocdc_nvm_image #(
        .WIDTH(ocdc_pkg::DATA_W),
        .DEPTH(ocdc_pkg::NVM_WORDS),
        .AW(ocdc_pkg::NVM_AW),
        .INIT({MARGIN_HI_INIT, DEVICE_CONTROL_INIT, IMAGE_REV_INIT})
    ) u_image (
        .mclk(mclk),
        .rst(rst),
        .wrEn(nvmWrEn),
        .wrAddr(nvmWrAddr),
        .wrData(nvmWrData),
        .rdEn(memRdEn),
        .rdAddr(memRdAddr),
        .rdData(memRdData)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // register file and startup sequencer
    ocdc_pkg::ocdc_state_e state_reg, state_next;
    logic [7:0] imageRev_reg, imageRev_next;
    logic [7:0] devCtl_reg, devCtl_next;
    logic [ocdc_pkg::MARGIN_HI_W-1:0] marginHi_reg, marginHi_next;
    logic [ocdc_pkg::NVM_AW-1:0] loadIdx_reg, loadIdx_next;
    logic capValid_reg, capValid_next;
    logic [ocdc_pkg::NVM_AW-1:0] capIdx_reg, capIdx_next;
    logic [ocdc_pkg::CAL_CNT_W-1:0] calCnt_reg, calCnt_next;
    ocdc_pkg::ocdc_pll_s pll_reg, pll_next;
    logic pdBit, autoBit, calBit, ctlWrite, trigWrite, startCal, calDone;

    assign pdBit = devCtl_reg[ocdc_pkg::BIT_PD];
    assign autoBit = devCtl_reg[ocdc_pkg::BIT_AUTO];
    assign calBit = devCtl_reg[ocdc_pkg::BIT_CAL];
    assign ctlWrite = regReq.wr && regReq.addr == ocdc_pkg::OFS_DEVICE_CONTROL;
    assign trigWrite = ctlWrite && regReq.wdata[ocdc_pkg::BIT_CAL] && !calBit;
    assign calDone = state_reg == ocdc_pkg::ST_CAL && calCnt_reg == CAL_LAST;

    // the host may start a calibration only once startup has settled
    always_comb begin
        startCal = 1'b0;
        case (state_reg)
            ocdc_pkg::ST_HALT,
            ocdc_pkg::ST_LOCK,
            ocdc_pkg::ST_RUN: startCal = trigWrite && !pdBit;
            default: startCal = 1'b0;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        imageRev_next = imageRev_reg;
        devCtl_next = devCtl_reg;
        marginHi_next = marginHi_reg;
        loadIdx_next = loadIdx_reg;
        capValid_next = 1'b0;
        capIdx_next = capIdx_reg;
        calCnt_next = calCnt_reg;
        memRdEn = 1'b0;
        memRdAddr = loadIdx_reg;
        // host writes; the trigger bit is owned by the sequencer
        if (ctlWrite) begin
            devCtl_next = (devCtl_reg & ~ocdc_pkg::DEVICE_CONTROL_HOST_MASK)
                | (regReq.wdata & ocdc_pkg::DEVICE_CONTROL_HOST_MASK);
        end
        if (regReq.wr && regReq.addr == ocdc_pkg::OFS_MARGIN_HI) begin
            marginHi_next = regReq.wdata[ocdc_pkg::MARGIN_HI_W-1:0];
        end
        // image words land one cycle after their read
        if (capValid_reg) begin
            case (capIdx_reg)
                ocdc_pkg::NVM_IDX_REV: imageRev_next = memRdData;
                ocdc_pkg::NVM_IDX_CTL: begin
                    devCtl_next = memRdData & ocdc_pkg::DEVICE_CONTROL_HOST_MASK;
                end
                ocdc_pkg::NVM_IDX_MARGIN: begin
                    marginHi_next = memRdData[ocdc_pkg::MARGIN_HI_W-1:0];
                end
                default: imageRev_next = imageRev_reg;
            endcase
        end
        // a commit refreshes the revision; during loading the load reads it anyway
        if (nvmCommit && state_reg != ocdc_pkg::ST_LOAD) begin
            memRdEn = 1'b1;
            memRdAddr = ocdc_pkg::NVM_IDX_REV;
            capValid_next = 1'b1;
            capIdx_next = ocdc_pkg::NVM_IDX_REV;
        end
        case (state_reg)
            ocdc_pkg::ST_LOAD: begin
                if (loadIdx_reg != ocdc_pkg::NVM_IDX_END) begin
                    memRdEn = 1'b1;
                    memRdAddr = loadIdx_reg;
                    capValid_next = 1'b1;
                    capIdx_next = loadIdx_reg;
                    loadIdx_next = loadIdx_reg + ocdc_pkg::NVM_AW'(1);
                end else if (!capValid_reg) begin
                    state_next = ocdc_pkg::ST_CONFIG;
                end
            end
            ocdc_pkg::ST_CONFIG: begin
                // powerdown first, then auto start alone decides
                if (pdBit) begin
                    state_next = ocdc_pkg::ST_PLL_OFF;
                end else if (autoBit) begin
                    state_next = ocdc_pkg::ST_CAL;
                end else begin
                    state_next = ocdc_pkg::ST_HALT;
                end
            end
            ocdc_pkg::ST_HALT: begin
                if (pdBit) begin
                    state_next = ocdc_pkg::ST_PLL_OFF;
                end else if (startCal) begin
                    state_next = ocdc_pkg::ST_CAL;
                end
            end
            ocdc_pkg::ST_PLL_OFF: begin
                if (!pdBit) begin
                    state_next = ocdc_pkg::ST_CAL;
                end
            end
            ocdc_pkg::ST_CAL: begin
                calCnt_next = calCnt_reg + ocdc_pkg::CAL_CNT_W'(1);
                if (pdBit) begin
                    state_next = ocdc_pkg::ST_PLL_OFF;
                    devCtl_next[ocdc_pkg::BIT_CAL] = 1'b0;
                end else if (calDone) begin
                    state_next = ocdc_pkg::ST_LOCK;
                    devCtl_next[ocdc_pkg::BIT_CAL] = 1'b0;
                end
            end
            ocdc_pkg::ST_LOCK: begin
                if (pdBit) begin
                    state_next = ocdc_pkg::ST_PLL_OFF;
                end else if (startCal) begin
                    state_next = ocdc_pkg::ST_CAL;
                end else if (pllLockRaw) begin
                    state_next = ocdc_pkg::ST_RUN;
                end
            end
            ocdc_pkg::ST_RUN: begin
                if (pdBit) begin
                    state_next = ocdc_pkg::ST_PLL_OFF;
                end else if (startCal) begin
                    state_next = ocdc_pkg::ST_CAL;
                end else if (!pllLockRaw) begin
                    state_next = ocdc_pkg::ST_LOCK;
                end
            end
            default: state_next = ocdc_pkg::ST_LOAD;
        endcase
        if (startCal) begin
            devCtl_next[ocdc_pkg::BIT_CAL] = 1'b1;
        end
        if (state_next == ocdc_pkg::ST_CAL && state_reg != ocdc_pkg::ST_CAL) begin
            calCnt_next = '0;
        end
        // outputs follow the state being entered, so they come from flops
        pll_next.pllEnable = state_next inside {ocdc_pkg::ST_CAL, ocdc_pkg::ST_LOCK,
            ocdc_pkg::ST_RUN};
        pll_next.calReset = state_next != ocdc_pkg::ST_CAL;
        pll_next.calBusy = state_next == ocdc_pkg::ST_CAL;
        pll_next.outEnable = state_next == ocdc_pkg::ST_RUN;
        // any device reset restarts from the image; the image survives pin and software resets
        if (devRst) begin
            state_next = ocdc_pkg::ST_LOAD;
            imageRev_next = ocdc_pkg::RST_IMAGE_REV;
            devCtl_next = ocdc_pkg::RST_DEVICE_CONTROL;
            marginHi_next = ocdc_pkg::RST_MARGIN_HI[ocdc_pkg::MARGIN_HI_W-1:0];
            loadIdx_next = ocdc_pkg::NVM_IDX_REV;
            capValid_next = 1'b0;
            calCnt_next = '0;
            pll_next = '0;
            pll_next.calReset = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= ocdc_pkg::ST_LOAD;
            imageRev_reg <= ocdc_pkg::RST_IMAGE_REV;
            devCtl_reg <= ocdc_pkg::RST_DEVICE_CONTROL;
            marginHi_reg <= ocdc_pkg::RST_MARGIN_HI[ocdc_pkg::MARGIN_HI_W-1:0];
            loadIdx_reg <= ocdc_pkg::NVM_IDX_REV;
            capValid_reg <= 1'b0;
            capIdx_reg <= ocdc_pkg::NVM_IDX_REV;
            calCnt_reg <= '0;
            pll_reg <= '{pllEnable: 1'b0, calReset: 1'b1, calBusy: 1'b0, outEnable: 1'b0};
        end else begin
            state_reg <= state_next;
            imageRev_reg <= imageRev_next;
            devCtl_reg <= devCtl_next;
            marginHi_reg <= marginHi_next;
            loadIdx_reg <= loadIdx_next;
            capValid_reg <= capValid_next;
            capIdx_reg <= capIdx_next;
            calCnt_reg <= calCnt_next;
            pll_reg <= pll_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path; reserved bits read as zero, unmapped offsets read zero
    logic [7:0] rdData_reg, rdData_next;
    logic rdValid_reg, rdValid_next;

    always_comb begin
        rdData_next = rdData_reg;
        rdValid_next = regReq.rd;
        if (regReq.rd) begin
            case (regReq.addr)
                ocdc_pkg::OFS_IMAGE_REV: rdData_next = imageRev_reg;
                ocdc_pkg::OFS_DEVICE_CONTROL: rdData_next = devCtl_reg & ocdc_pkg::DEVICE_CONTROL_RD_MASK;
                ocdc_pkg::OFS_MARGIN_HI: begin
                    rdData_next = 8'(marginHi_reg) & ocdc_pkg::MARGIN_RD_MASK;
                end
                default: rdData_next = ocdc_pkg::RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdData_reg <= ocdc_pkg::RD_UNMAPPED;
            rdValid_reg <= 1'b0;
        end else begin
            rdData_reg <= rdData_next;
            rdValid_reg <= rdValid_next;
        end
    end

    assign regRdata = rdData_reg;
    assign regRdValid = rdValid_reg;
    assign pllCtl = pll_reg;
    assign marginHigh = marginHi_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_cal_started;
        pllCtl.calBusy && pllCtl.pllEnable && !pllCtl.calReset;
    endsequence

    sequence s_cal_finished;
        !calBit ##0 pllCtl.pllEnable && !pllCtl.calBusy;
    endsequence

    a_reset_reload: assert property (devRst |=> state_reg == ocdc_pkg::ST_LOAD)
        else $error("device reset did not restart loading");
    a_commit_rev: assert property ((nvmCommit && state_reg != ocdc_pkg::ST_LOAD && !devRst)
        ##1 !devRst |=> imageRev_reg == $past(memRdData))
        else $error("revision not refreshed after commit");
    a_pd_start: assert property ((state_reg == ocdc_pkg::ST_CONFIG && pdBit && !devRst)
        |=> !pllCtl.pllEnable && state_reg == ocdc_pkg::ST_PLL_OFF)
        else $error("powerdown did not keep pll off at startup");
    a_pd_holds_off: assert property ((pdBit && !devRst) |=> !pllCtl.pllEnable
        && pllCtl.calReset)
        else $error("pll not disabled under powerdown");
    a_pd_clear_cal: assert property ((state_reg == ocdc_pkg::ST_PLL_OFF && !pdBit
        && !devRst) |=> s_cal_started)
        else $error("no recalibration after powerdown cleared");
    a_trig_start: assert property ((startCal && !devRst) |=> s_cal_started ##0 calBit)
        else $error("trigger edge did not start calibration");
    a_cal_clear: assert property ((calDone && !pdBit && !devRst) |=> s_cal_finished)
        else $error("trigger bit not cleared at calibration end");
    a_startup_auto: assert property ((state_reg inside {ocdc_pkg::ST_LOAD,
        ocdc_pkg::ST_CONFIG} && trigWrite && !devRst) |=> !calBit)
        else $error("trigger acted during startup");
    a_auto_start: assert property ((state_reg == ocdc_pkg::ST_CONFIG && autoBit && !pdBit
        && !devRst) |=> s_cal_started ##0 state_reg == ocdc_pkg::ST_CAL)
        else $error("auto start did not calibrate");
    a_halt_manual: assert property ((state_reg == ocdc_pkg::ST_CONFIG && !autoBit && !pdBit
        && !devRst) |=> state_reg == ocdc_pkg::ST_HALT && !pllCtl.pllEnable)
        else $error("device did not halt without auto start");
    a_margin_read: assert property ((regReq.rd && regReq.addr == ocdc_pkg::OFS_MARGIN_HI
        && !devRst) |=> regRdValid && regRdata[7:2] == 6'h00
        && regRdata[1:0] == $past(marginHi_reg))
        else $error("margin high readback wrong");
    a_cal_no_restart: assert property ((state_reg == ocdc_pkg::ST_CAL && !calDone && !pdBit
        && !devRst) |=> state_reg == ocdc_pkg::ST_CAL && calBit == $past(calBit)
        && calCnt_reg == $past(calCnt_reg) + ocdc_pkg::CAL_CNT_W'(1))
        else $error("calibration restarted or aborted");

endmodule

// *** verif/ocdc_pll_model.sv ***
`timescale 1ns/1ps
// far side stand-in: reports lock a fixed time after the loop runs calm
module ocdc_pll_model #(
    parameter int LOCK_DLY = 6
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // controls from the block and lock back to it
    input wire ocdc_pkg::ocdc_pll_s pllCtl,
    output logic pllLockRaw
);
    int cnt;
    // lock drops at once when the loop is disturbed, as a real loop would;
    // the calibration reset stays high outside calibration, so it is no disturbance
    always @(posedge mclk) begin
        if (rst || !pllCtl.pllEnable || pllCtl.calBusy) begin
            cnt <= 0;
        end else if (cnt < LOCK_DLY) begin
            cnt <= cnt + 1;
        end
    end
    assign pllLockRaw = (cnt == LOCK_DLY);
endmodule

// *** verif/oscillator_device_control_regs_tb_top.sv ***
`timescale 1ns/1ps
module oscillator_device_control_regs_tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic hwResetPinN = 1'b1;
    logic swResetReq = 1'b0;
    ocdc_pkg::ocdc_req_s regReq = '0;
    logic [7:0] regRdata;
    logic regRdValid;
    logic nvmWrEn = 1'b0;
    logic [1:0] nvmWrAddr = 2'h0;
    logic [7:0] nvmWrData = 8'h00;
    logic nvmCommit = 1'b0;
    logic pllLockRaw;
    ocdc_pkg::ocdc_pll_s pllCtl;
    logic [1:0] marginHigh;
    int n_fail = 0;
    int compares = 0;
    logic [7:0] rv;
    // rows: write flag, address, write data, expected read back
    localparam logic [24:0] ROWS [9] = '{
        {1'b0, 8'h09, 8'h00, 8'h00}, {1'b0, 8'h0a, 8'h00, 8'h01},
        {1'b0, 8'h10, 8'h00, 8'h00}, {1'b1, 8'h09, 8'hff, 8'h00},
        {1'b1, 8'h10, 8'hff, 8'h03}, {1'b1, 8'h10, 8'h02, 8'h02},
        {1'b1, 8'h0a, 8'hbd, 8'h3d}, {1'b1, 8'h0a, 8'h01, 8'h01},
        {1'b1, 8'h20, 8'h55, 8'h00}};

    always #2.5 mclk = ~mclk;

    // four cycles of calibration keep the run short
    ocdc_device_ctl #(.CAL_TIME_NS(20)) u_ocdc_device_ctl (
        .mclk(mclk), .rst(rst), .hwResetPinN(hwResetPinN), .swResetReq(swResetReq),
        .regReq(regReq), .regRdata(regRdata), .regRdValid(regRdValid),
        .nvmWrEn(nvmWrEn), .nvmWrAddr(nvmWrAddr), .nvmWrData(nvmWrData),
        .nvmCommit(nvmCommit), .pllLockRaw(pllLockRaw), .pllCtl(pllCtl),
        .marginHigh(marginHigh));
    ocdc_pll_model u_ocdc_pll_model (.mclk(mclk), .rst(rst), .pllCtl(pllCtl),
        .pllLockRaw(pllLockRaw));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask
    // a register write is taken at the edge after it is set up
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) regReq <= '{1'b1, 1'b0, a, d};
        @(posedge mclk) regReq <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk) regReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk) regReq <= '0;
        #1;
        chk({7'h0, regRdValid}, 8'h01, "read valid");
        d = regRdata;
    endtask
    // waits on selected control outputs; a spent bound is a mismatch
    task automatic waitCtl(input logic [3:0] m, input logic [3:0] v, input int bound);
        int i;
        for (i = 0; i < bound && (pllCtl & m) !== v; i++) begin
            @(posedge mclk);
            #1;
        end
        chk({4'h0, pllCtl & m}, {4'h0, v}, "control wait");
        if ((pllCtl & m) !== v) stop_test();
    endtask
    task automatic nvm(input logic [1:0] a, input logic [7:0] d, input logic cmt);
        @(posedge mclk) {nvmWrEn, nvmWrAddr, nvmWrData} <= {1'b1, a, d};
        @(posedge mclk) {nvmWrEn, nvmCommit} <= {1'b0, cmt};
        @(posedge mclk) nvmCommit <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic swRst();
        @(posedge mclk) swResetReq <= 1'b1;
        @(posedge mclk) swResetReq <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk({4'h0, pllCtl}, 8'h04, "reset controls");
        waitCtl(4'h2, 4'h2, 12);
        waitCtl(4'h1, 4'h1, 40);
        foreach (ROWS[i]) begin
            if (ROWS[i][24]) wr(ROWS[i][23:16], ROWS[i][15:8]);
            rd(ROWS[i][23:16], rv);
            chk(rv, ROWS[i][7:0], "register row");
        end
        wr(8'h10, 8'h03);
        #1;
        chk({6'h0, marginHigh}, 8'h03, "margin pins");
        // powerdown stops the loop, clearing it recalibrates unasked
        wr(8'h0a, 8'h41);
        waitCtl(4'hc, 4'h4, 2);
        repeat (10) @(posedge mclk);
        chk({4'h0, pllCtl & 4'hd}, 8'h04, "still off");
        wr(8'h0a, 8'h01);
        waitCtl(4'ha, 4'ha, 3);
        waitCtl(4'h1, 4'h1, 30);
        // commit refreshes the revision from image word 0
        nvm(2'h0, 8'h3c, 1'b1);
        rd(8'h09, rv);
        chk(rv, 8'h3c, "revision after commit");
        // auto start off in the image: software reset halts after config
        nvm(2'h1, 8'h00, 1'b0);
        wr(8'h10, 8'h02);
        swRst();
        // a trigger while the image loads is dropped
        wr(8'h0a, 8'h02);
        repeat (20) @(posedge mclk);
        chk({4'h0, pllCtl & 4'h3}, 8'h00, "halted");
        rd(8'h0a, rv);
        chk(rv, 8'h00, "trigger ignored while loading");
        rd(8'h09, rv);
        chk(rv, 8'h3c, "revision after reset");
        rd(8'h10, rv);
        chk(rv, 8'h00, "margin after reset");
        wr(8'h0a, 8'h02);
        #1;
        chk({7'h0, pllCtl.calBusy}, 8'h01, "trigger starts");
        // a second trigger lands mid calibration and must not restart the count
        wr(8'h0a, 8'h02);
        #1;
        chk({7'h0, pllCtl.calBusy}, 8'h01, "no restart");
        rd(8'h0a, rv);
        chk(rv, 8'h02, "trigger reads set");
        // a restart would keep the loop busy two edges past this point
        waitCtl(4'h2, 4'h0, 1);
        rd(8'h0a, rv);
        chk(rv, 8'h00, "trigger self clears");
        waitCtl(4'h1, 4'h1, 30);
        // powerdown in the image: the loop stays off after a pin reset
        nvm(2'h1, 8'h41, 1'b0);
        @(posedge mclk) hwResetPinN <= 1'b0;
        repeat (8) @(posedge mclk);
        hwResetPinN <= 1'b1;
        repeat (30) @(posedge mclk);
        chk({4'h0, pllCtl & 4'hf}, 8'h04, "powerdown start");
        rd(8'h0a, rv);
        chk(rv, 8'h41, "control from image");
        stop_test();
    end
endmodule
